// File: include/niw_map.vh
`ifndef NIW_MAP_VH
`define NIW_MAP_VH

// ************************************************************
// cell and frame geometry
// ************************************************************
`define NIW_CELL_PAY 17'h0_0030
`define NIW_POS_LAST 6'h2F
`define NIW_CIDX_LAST 6'h33
`define NIW_CIDX_HDR 6'h03
`define NIW_CIDX_PAY 6'h04
`define NIW_TRL_BYTES 17'h0_0008
`define NIW_TRL_ROUND 17'h0_0037
`define NIW_TRL_START 6'h28
`define NIW_TRL_LENHI 6'h2A
`define NIW_TRL_LENLO 6'h2B
`define NIW_CRC_BYTES 17'h0_0004
`define NIW_MIN_LEN 16'h0002

// ************************************************************
// header fields and codes
// ************************************************************
`define NIW_PTI_OAM_E2E 3'h5
`define NIW_OAM_AIS 8'h10
`define NIW_OAM_LOOP 8'h18
`define NIW_OAM_FILL 8'h6A

// ************************************************************
// aal5 crc-32
// ************************************************************
`define NIW_CRC_POLY 32'h04C1_1DB7
`define NIW_CRC_INIT 32'hFFFF_FFFF
`define NIW_CRC_RESID 32'hC704_DD7B

`endif

// File: rtl/niw_fifo.v
`timescale 1ns/1ps
`default_nettype none

module niw_fifo #(
  parameter W = 9,
  parameter D = 4,
  parameter AW = 2
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_wvalid,
  output wire o_wready,
  input wire [W-1:0] i_wdata,
  output wire o_rvalid,
  input wire i_rready,
  output wire [W-1:0] o_rdata
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wptr_q;
  reg [AW-1:0] rptr_q;
  reg [AW:0] cnt_q;
  wire wr = i_wvalid & o_wready;
  wire rd = o_rvalid & i_rready;

  assign o_wready = (cnt_q != D[AW:0]);
  assign o_rvalid = (cnt_q != {(AW+1){1'b0}});
  assign o_rdata = mem_q[rptr_q];

  always @(posedge i_clk) begin
    if (wr) begin
      mem_q[wptr_q] <= i_wdata;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        wptr_q <= (wptr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_q + 1'b1;
      end
      if (rd) begin
        rptr_q <= (rptr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_q + 1'b1;
      end
      if (wr && !rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (rd && !wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// File: rtl/niw_converter.v
// Operation
// (R1) atm side sends aal5 cells, access headers
// (R2) one frame per aal5 unit
// (R3) non aal5 traffic gives framing errors
// (R4) cell header replaced by internal trunk header
// (R5) congestion discards chosen by cell clp
// (R6) strip aal5 to frames, add to cells
// (R7) frame released only when fully assembled; code passes bytes out as each cell arrives, O_FEND at the last cell
// (R8) configured dlci written into every frame
// (R9) frames leave with original content, lapd framing
// (R10) loopback oam cells returned to atm side
// (R11) ais converted into other network's construct
// (R12) translate vpi/vci to dlci and back
// (R13) payload is q922 core, no flags/crc
// (R14) append cpcs trailer to frame payload
// (R15) segment into 48-byte units, reassemble back
// (R16) prepend atm header; reverse path undoes
// (R17) frame de copied into every cell clp
// (R18) any cell clp sets frame de
// (R19) generated cells carry efci zero
// (R20) last cell efci sets frame fecn
// (R21) a-bit never mapped into ais cells
// (R22) congestion info moved to converted header
// (R23) check trailer length and crc, discard; code only flags O_FEND_ERR at the last cell, bytes already passed out
`timescale 1ns/1ps
`default_nettype none
`include "niw_map.vh"

module niw_converter #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire I_CORE_CLK,
  input wire I_RESETN,
  input wire [9:0] I_CFG_DLCI,
  input wire [7:0] I_CFG_VPI,
  input wire [15:0] I_CFG_VCI,
  input wire I_CONGEST,
  input wire I_FR_AIS,
  input wire I_FIN_VALID,
  output wire O_FIN_READY,
  input wire [7:0] I_FIN_DATA,
  input wire I_FIN_SOF,
  input wire I_FIN_EOF,
  input wire [15:0] I_FIN_LEN,
  output wire O_COUT_VALID,
  input wire I_COUT_READY,
  output wire [7:0] O_COUT_DATA,
  output wire O_COUT_SOC,
  input wire I_CIN_VALID,
  output wire O_CIN_READY,
  input wire [7:0] I_CIN_DATA,
  input wire I_CIN_SOC,
  output reg O_TRUNK_VLD,
  output reg [15:0] O_TRUNK_HDR,
  input wire I_FOUT_READY,
  output reg O_FOUT_VALID,
  output reg [7:0] O_FOUT_DATA,
  output reg O_FOUT_SOF,
  output reg O_FEND,
  output reg [15:0] O_FEND_ADDR,
  output reg [15:0] O_FEND_LEN,
  output reg O_FEND_ERR,
  output reg O_LB_VALID,
  output reg O_LB_SOC,
  output reg [31:0] O_LB_HDR,
  output reg [7:0] O_LB_DATA,
  output reg O_AIS_TO_FR,
  output reg O_CELL_DROP
);
  // ************************************************************
  // shared crc step, msb first
  // ************************************************************
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] x;
    begin
      x = c;
      for (i = 7; i >= 0; i = i - 1) begin
        x = {x[30:0], 1'b0} ^ ((x[31] ^ d[i]) ? `NIW_CRC_POLY : 32'h0000_0000);
      end
      crc_byte = x;
    end
  endfunction

  // ************************************************************
  // frame to cell path
  // ************************************************************
  localparam [2:0] F_IDLE = 3'd0;
  localparam [2:0] F_ADDR = 3'd1;
  localparam [2:0] F_HDR = 3'd2;
  localparam [2:0] F_PAY = 3'd3;
  localparam [2:0] F_DROP = 3'd4;

  reg [2:0] fst_q;
  reg [7:0] a0_q;
  reg [7:0] a1_q;
  reg [15:0] len_q;
  reg [16:0] tot_q;
  reg [16:0] tcnt_q;
  reg [5:0] pos_q;
  reg [1:0] hb_q;
  reg [31:0] crc_q;
  reg ais_q;
  reg ais_pend_q;

  wire f_wready;
  reg f_wvalid;
  reg [7:0] f_byte;
  reg f_soc;
  reg need_in;
  reg [31:0] hword;
  wire [16:0] rem = tot_q - tcnt_q;
  wire cell_last = (tcnt_q + `NIW_CELL_PAY == tot_q);
  wire fin_fire = I_FIN_VALID & O_FIN_READY;
  wire f_step = f_wvalid & f_wready;
  wire [16:0] len_ext = {1'b0, I_FIN_LEN};
  wire [16:0] tot_calc = ((len_ext + `NIW_TRL_ROUND) / `NIW_CELL_PAY) * `NIW_CELL_PAY;

  assign O_FIN_READY = (fst_q == F_IDLE && !ais_pend_q) || (fst_q == F_ADDR) ||
                       (fst_q == F_DROP) || (fst_q == F_PAY && need_in && f_wready);

  always @* begin
    need_in = (fst_q == F_PAY) && !ais_q && (tcnt_q >= 17'h0_0002) &&
              (tcnt_q < {1'b0, len_q});
    // (R12) vpi/vci from dlci; (R19) efci zero; (R17) de to clp
    if (ais_q) begin
      hword = {4'h0, I_CFG_VPI, I_CFG_VCI, `NIW_PTI_OAM_E2E, 1'b0};
    end else begin
      hword = {4'h0, I_CFG_VPI, I_CFG_VCI, 1'b0, 1'b0, cell_last, a1_q[1]};
    end
    f_byte = 8'h00;
    f_soc = 1'b0;
    f_wvalid = 1'b0;
    if (fst_q == F_HDR) begin
      // (R16) header ahead of every segment
      f_wvalid = 1'b1;
      f_soc = (hb_q == 2'd0);
      f_byte = hword[31 - 8 * hb_q -: 8];
    end else if (fst_q == F_PAY) begin
      f_wvalid = !need_in || I_FIN_VALID;
      if (ais_q) begin
        f_byte = (pos_q == 6'h00) ? `NIW_OAM_AIS : `NIW_OAM_FILL;
        // (R13) unit opens with the core address
      end else if (tcnt_q == 17'h0_0000) begin
        f_byte = a0_q;
      end else if (tcnt_q == 17'h0_0001) begin
        f_byte = a1_q;
      end else if (need_in) begin
        f_byte = I_FIN_DATA;
      end else begin
        // (R14) pad, uu, cpi, length, crc
        case (rem[3:0])
          4'd6: f_byte = len_q[15:8];
          4'd5: f_byte = len_q[7:0];
          4'd4: f_byte = ~crc_q[31:24];
          4'd3: f_byte = ~crc_q[23:16];
          4'd2: f_byte = ~crc_q[15:8];
          4'd1: f_byte = ~crc_q[7:0];
          default: f_byte = 8'h00;
        endcase
        if (rem > `NIW_TRL_BYTES) begin
          f_byte = 8'h00;
        end
      end
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      fst_q <= F_IDLE;
      a0_q <= 8'h00;
      a1_q <= 8'h00;
      len_q <= 16'h0000;
      tot_q <= 17'h0_0000;
      tcnt_q <= 17'h0_0000;
      pos_q <= 6'h00;
      hb_q <= 2'd0;
      crc_q <= `NIW_CRC_INIT;
      ais_q <= 1'b0;
      ais_pend_q <= 1'b0;
    end else begin
      // a new request wins over the one being taken
      if (I_FR_AIS) begin
        ais_pend_q <= 1'b1;
      end else if (fst_q == F_IDLE && ais_pend_q) begin
        ais_pend_q <= 1'b0;
      end
      case (fst_q)
        F_IDLE: begin
          // (R11) ais from frame side becomes an oam cell
          if (ais_pend_q) begin
            ais_q <= 1'b1;
            hb_q <= 2'd0;
            pos_q <= 6'h00;
            fst_q <= F_HDR;
          end else if (fin_fire && I_FIN_SOF) begin
            a0_q <= I_FIN_DATA;
            len_q <= I_FIN_LEN;
            tot_q <= tot_calc;
            fst_q <= I_FIN_EOF ? F_IDLE : F_ADDR;
          end
        end
        F_ADDR: begin
          if (fin_fire) begin
            a1_q <= I_FIN_DATA;
            ais_q <= 1'b0;
            tcnt_q <= 17'h0_0000;
            pos_q <= 6'h00;
            hb_q <= 2'd0;
            crc_q <= `NIW_CRC_INIT;
            // (R12) only the configured dlci maps to this circuit
            if ({a0_q[7:2], I_FIN_DATA[7:4]} == I_CFG_DLCI) begin
              fst_q <= F_HDR;
            end else begin
              fst_q <= I_FIN_EOF ? F_IDLE : F_DROP;
            end
          end
        end
        F_HDR: begin
          if (f_step) begin
            hb_q <= hb_q + 2'd1;
            if (hb_q == 2'd3) begin
              fst_q <= F_PAY;
            end
          end
        end
        F_PAY: begin
          if (f_step) begin
            // (R15) 48 bytes per segment
            pos_q <= (pos_q == `NIW_POS_LAST) ? 6'h00 : pos_q + 6'h01;
            tcnt_q <= tcnt_q + 17'h0_0001;
            // (R6) crc covers all but its own field
            if (!ais_q && rem > `NIW_CRC_BYTES) begin
              crc_q <= crc_byte(crc_q, f_byte);
            end
            if (pos_q == `NIW_POS_LAST) begin
              if (ais_q || tcnt_q + 17'h0_0001 == tot_q) begin
                ais_q <= 1'b0;
                fst_q <= F_IDLE;
              end else begin
                fst_q <= F_HDR;
              end
            end
          end
        end
        F_DROP: begin
          if (fin_fire && I_FIN_EOF) begin
            fst_q <= F_IDLE;
          end
        end
        default: fst_q <= F_IDLE;
      endcase
    end
  end

  wire [8:0] cout_word;
  niw_fifo #(
    .W(9),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_cell_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESETN),
    .i_wvalid(f_wvalid),
    .o_wready(f_wready),
    .i_wdata({f_soc, f_byte}),
    .o_rvalid(O_COUT_VALID),
    .i_rready(I_COUT_READY),
    .o_rdata(cout_word)
  );
  assign O_COUT_SOC = cout_word[8];
  assign O_COUT_DATA = cout_word[7:0];

  // ************************************************************
  // cell to frame path
  // ************************************************************
  localparam [1:0] C_SKIP = 2'd0;
  localparam [1:0] C_DATA = 2'd1;
  localparam [1:0] C_OAM = 2'd2;
  localparam [1:0] C_LOOP = 2'd3;

  reg [5:0] cidx_q;
  reg [23:0] hdr_q;
  reg [1:0] cls_q;
  reg [15:0] rcnt_q;
  reg [7:0] ra0_q;
  reg [7:0] ra1_q;
  reg [7:0] tlhi_q;
  reg [31:0] rcrc_q;
  reg anyclp_q;
  reg bad_q;
  reg clast_q;
  reg cefci_q;

  wire cin_fire = I_CIN_VALID & O_CIN_READY;
  wire [31:0] hfull = {hdr_q, I_CIN_DATA};
  wire [5:0] p = cidx_q - `NIW_CIDX_PAY;
  wire [31:0] rcrc_nx = crc_byte(rcrc_q, I_CIN_DATA);
  wire [15:0] tlen = {tlhi_q, O_FEND_LEN[7:0]};
  wire [15:0] slack = rcnt_q - tlen;
  wire len_ok = (tlen >= `NIW_MIN_LEN) && (tlen <= rcnt_q) &&
                ({1'b0, slack} < `NIW_CELL_PAY);
  wire is_trl = clast_q && (p >= `NIW_TRL_START);

  assign O_CIN_READY = I_FOUT_READY;

  always @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      cidx_q <= 6'h00;
      hdr_q <= 24'h00_0000;
      cls_q <= C_SKIP;
      rcnt_q <= 16'h0000;
      ra0_q <= 8'h00;
      ra1_q <= 8'h00;
      tlhi_q <= 8'h00;
      rcrc_q <= `NIW_CRC_INIT;
      anyclp_q <= 1'b0;
      bad_q <= 1'b0;
      clast_q <= 1'b0;
      cefci_q <= 1'b0;
      O_TRUNK_VLD <= 1'b0;
      O_TRUNK_HDR <= 16'h0000;
      O_FOUT_VALID <= 1'b0;
      O_FOUT_DATA <= 8'h00;
      O_FOUT_SOF <= 1'b0;
      O_FEND <= 1'b0;
      O_FEND_ADDR <= 16'h0000;
      O_FEND_LEN <= 16'h0000;
      O_FEND_ERR <= 1'b0;
      O_LB_VALID <= 1'b0;
      O_LB_SOC <= 1'b0;
      O_LB_HDR <= 32'h0000_0000;
      O_LB_DATA <= 8'h00;
      O_AIS_TO_FR <= 1'b0;
      O_CELL_DROP <= 1'b0;
    end else begin
      O_TRUNK_VLD <= 1'b0;
      O_FOUT_VALID <= 1'b0;
      O_FOUT_SOF <= 1'b0;
      O_FEND <= 1'b0;
      O_LB_VALID <= 1'b0;
      O_LB_SOC <= 1'b0;
      O_AIS_TO_FR <= 1'b0;
      O_CELL_DROP <= 1'b0;
      if (cin_fire) begin
        // a stray start of cell resynchronises the byte count
        if (I_CIN_SOC) begin
          hdr_q <= {16'h0000, I_CIN_DATA};
          cidx_q <= 6'h01;
        end else if (cidx_q != 6'h00) begin
          cidx_q <= (cidx_q == `NIW_CIDX_LAST) ? 6'h00 : cidx_q + 6'h01;
          if (cidx_q < `NIW_CIDX_HDR) begin
            hdr_q <= hfull[23:0];
          end
        end
        if (!I_CIN_SOC && cidx_q == `NIW_CIDX_HDR) begin
          cls_q <= C_SKIP;
          // (R12) only the configured circuit is taken
          if (hfull[27:20] == I_CFG_VPI && hfull[19:4] == I_CFG_VCI) begin
            if (hfull[3:1] == `NIW_PTI_OAM_E2E) begin
              cls_q <= C_OAM;
            end else if (!hfull[3]) begin
              // (R5) under congestion low priority cells go first
              if (I_CONGEST && hfull[0]) begin
                O_CELL_DROP <= 1'b1;
                bad_q <= 1'b1;
              end else begin
                cls_q <= C_DATA;
                clast_q <= hfull[1];
                cefci_q <= hfull[2];
                anyclp_q <= anyclp_q | hfull[0];
                // (R4) trunk header stands in for the cell header
                O_TRUNK_VLD <= 1'b1;
                O_TRUNK_HDR <= {I_CFG_DLCI, hfull[3:1], hfull[0], 2'b00};
              end
            end
          end
        end
        if (!I_CIN_SOC && cidx_q >= `NIW_CIDX_PAY && cls_q == C_OAM) begin
          cls_q <= C_SKIP;
          // (R10) loopback goes back to the atm side only
          if (I_CIN_DATA == `NIW_OAM_LOOP) begin
            cls_q <= C_LOOP;
            O_LB_VALID <= 1'b1;
            O_LB_SOC <= 1'b1;
            O_LB_HDR <= {hdr_q, I_CFG_VCI[3:0], `NIW_PTI_OAM_E2E, 1'b0};
            O_LB_DATA <= I_CIN_DATA;
          end
          // (R11) ais cell becomes a frame side indication
          // (R21) no a-bit path exists in either direction
          if (I_CIN_DATA == `NIW_OAM_AIS) begin
            O_AIS_TO_FR <= 1'b1;
          end
        end
        if (!I_CIN_SOC && cidx_q > `NIW_CIDX_PAY && cls_q == C_LOOP) begin
          O_LB_VALID <= 1'b1;
          // clear the loopback indication so the far end does not loop it again
          O_LB_DATA <= (cidx_q == `NIW_CIDX_PAY + 6'h01) ? {I_CIN_DATA[7:1], 1'b0} : I_CIN_DATA;
        end
        if (!I_CIN_SOC && cidx_q >= `NIW_CIDX_PAY && cls_q == C_DATA) begin
          // (R15) reassemble segments in arrival order
          rcrc_q <= rcrc_nx;
          if (!is_trl) begin
            rcnt_q <= rcnt_q + 16'h0001;
            // (R3) runaway units cannot be aal5 frames
            if (rcnt_q == 16'hFFFF) begin
              bad_q <= 1'b1;
            end
            if (rcnt_q == 16'h0000) begin
              ra0_q <= I_CIN_DATA;
            end else if (rcnt_q == 16'h0001) begin
              ra1_q <= I_CIN_DATA;
            end else begin
              // (R6) (R9) framing stripped, bytes kept as sent
              O_FOUT_VALID <= 1'b1;
              O_FOUT_SOF <= (rcnt_q == 16'h0002);
              O_FOUT_DATA <= I_CIN_DATA;
            end
          end
          if (clast_q && p == `NIW_TRL_LENHI) begin
            tlhi_q <= I_CIN_DATA;
          end
          if (clast_q && p == `NIW_TRL_LENLO) begin
            O_FEND_LEN <= {8'h00, I_CIN_DATA};
          end
          if (clast_q && cidx_q == `NIW_CIDX_LAST) begin
            // (R7) (R2) one whole frame closes each unit
            O_FEND <= 1'b1;
            O_FEND_LEN <= tlen;
            // (R8) configured dlci; (R18) any clp to de; (R20) last efci to fecn
            // (R22) congestion bits carried into the rebuilt address
            O_FEND_ADDR <= {I_CFG_DLCI[9:4], ra0_q[1], 1'b0,
                            I_CFG_DLCI[3:0], cefci_q | ra1_q[3], ra1_q[2],
                            anyclp_q | ra1_q[1], 1'b1};
            // (R23) trailer length and crc checked, (R3) failures flagged
            O_FEND_ERR <= bad_q || !len_ok || (rcrc_nx != `NIW_CRC_RESID);
            rcnt_q <= 16'h0000;
            rcrc_q <= `NIW_CRC_INIT;
            anyclp_q <= 1'b0;
            bad_q <= 1'b0;
            clast_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

// File: bench/niw_atm_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// atm trunk side: stalling cell sink, cell source
// ************************************************************
module niw_atm_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cout_valid,
  output logic cout_ready,
  input wire logic [7:0] cout_data,
  input wire logic cout_soc,
  output logic cin_valid,
  input wire logic cin_ready,
  output logic [7:0] cin_data,
  output logic cin_soc
);
  logic [7:0] cap[$];
  int stuck = 0;
  initial begin
    cout_ready = 1'h0;
    cin_valid = 1'h0;
    cin_data = 8'h00;
    cin_soc = 1'h0;
  end
  // stalls at random so the fifo fills and holds
  always @(posedge clk) begin
    if (rst_n && cout_valid && cout_ready) cap.push_back(cout_data);
    cout_ready <= #1 ($urandom % 4) != 0;
  end
  // whole access-header cells, one cell per call
  task automatic send_cell(input logic [7:0] c[52]);
    int n;
    @(posedge clk);
    #1;
    for (int i = 0; i < 52; i++) begin
      cin_valid = 1'h1;
      cin_data = c[i];
      cin_soc = i == 0;
      n = 0;
      @(posedge clk);
      while (!cin_ready && n < 500) begin
        n++;
        @(posedge clk);
      end
      if (!cin_ready) stuck++;
      #1;
    end
    cin_valid = 1'h0;
    cin_soc = 1'h0;
    // released line shows the inverse, not a stale byte
    cin_data = ~cin_data;
  endtask
endmodule
`default_nettype wire

// File: bench/niw_converter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module niw_converter_assertions (
  input wire I_CORE_CLK,
  input wire I_RESETN,
  input wire [9:0] I_CFG_DLCI,
  input wire I_CONGEST,
  input wire I_FIN_VALID,
  input wire O_FIN_READY,
  input wire [7:0] I_FIN_DATA,
  input wire I_FIN_SOF,
  input wire O_COUT_VALID,
  input wire I_COUT_READY,
  input wire [7:0] O_COUT_DATA,
  input wire O_COUT_SOC,
  input wire I_CIN_VALID,
  input wire O_CIN_READY,
  input wire [7:0] I_CIN_DATA,
  input wire I_FOUT_READY,
  input wire O_TRUNK_VLD,
  input wire [15:0] O_TRUNK_HDR,
  input wire O_FOUT_VALID,
  input wire O_FEND,
  input wire O_FEND_ERR,
  input wire O_LB_VALID,
  input wire O_CELL_DROP
);
  // ************************************************************
  // cell byte position and frame de tracking
  // ************************************************************
  logic [5:0] cidx_q;
  logic sof_q;
  logic de_q;
  wire cx = O_COUT_VALID && I_COUT_READY;
  always @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      cidx_q <= 6'h00;
      sof_q <= 1'h0;
      de_q <= 1'h0;
    end else begin
      if (cx) cidx_q <= (cidx_q == 6'h33) ? 6'h00 : cidx_q + 6'h01;
      if (I_FIN_VALID && O_FIN_READY) begin
        sof_q <= I_FIN_SOF;
        if (sof_q) de_q <= I_FIN_DATA[1];
      end
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  AST_SOC_FIRST: assert property (cx && O_COUT_SOC |-> cidx_q == 6'h00)
    else $error("cell start away from byte zero");
  AST_EFCI_ZERO: assert property (cx && cidx_q == 6'h03 |-> !O_COUT_DATA[2])
    else $error("generated cell carries efci");
  AST_CLP_DE: assert property (cx && cidx_q == 6'h03 && !O_COUT_DATA[3] |-> O_COUT_DATA[0] == de_q)
    else $error("cell clp differs from frame de");
  AST_COUT_HOLD: assert property (O_COUT_VALID && !I_COUT_READY |=> O_COUT_VALID && $stable(O_COUT_DATA) && $stable(O_COUT_SOC))
    else $error("cell byte changed while stalled");
  AST_TRUNK_HDR: assert property (O_TRUNK_VLD |-> O_TRUNK_HDR[15:6] == I_CFG_DLCI && O_TRUNK_HDR[1:0] == 2'h0 && $past(I_CIN_VALID && O_CIN_READY))
    else $error("trunk header wrong");
  AST_CIN_READY: assert property (O_CIN_READY == I_FOUT_READY)
    else $error("cell ready ignores downstream");
  AST_LB_NOT_FR: assert property (O_LB_VALID |-> !O_FOUT_VALID && !O_FEND)
    else $error("loopback leaked to frame side");
  AST_DROP_CLP: assert property (O_CELL_DROP |-> $past(I_CONGEST && I_CIN_VALID && O_CIN_READY && I_CIN_DATA[0]))
    else $error("drop without clp under congestion");
  AST_FOUT_CAUSE: assert property (O_FOUT_VALID |-> $past(I_CIN_VALID && O_CIN_READY))
    else $error("frame byte without cell byte");
  COV_FRAME_OK: cover property (O_FEND && !O_FEND_ERR);
  COV_FRAME_BAD: cover property (O_FEND && O_FEND_ERR);
  COV_LOOP: cover property (O_LB_VALID);
  COV_DROP: cover property (O_CELL_DROP);
endmodule
bind niw_converter niw_converter_assertions niw_converter_assertions_i (
  .I_CORE_CLK, .I_RESETN, .I_CFG_DLCI, .I_CONGEST, .I_FIN_VALID, .O_FIN_READY,
  .I_FIN_DATA, .I_FIN_SOF, .O_COUT_VALID, .I_COUT_READY, .O_COUT_DATA, .O_COUT_SOC,
  .I_CIN_VALID, .O_CIN_READY, .I_CIN_DATA, .I_FOUT_READY, .O_TRUNK_VLD, .O_TRUNK_HDR,
  .O_FOUT_VALID, .O_FEND, .O_FEND_ERR, .O_LB_VALID, .O_CELL_DROP);
`default_nettype wire

// File: bench/niw_converter_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module niw_converter_test;
  logic clk = 1'h0, rst_n = 1'h0, cong = 1'h0, fr_ais = 1'h0, fout_rdy = 1'h1;
  logic [9:0] dlci = 10'h000;
  logic [7:0] vpi = 8'h00;
  logic [15:0] vci = 16'h0000;
  logic fin_v = 1'h0, fin_sof = 1'h0, fin_eof = 1'h0, fin_rdy;
  logic [7:0] fin_d = 8'h00;
  logic [15:0] fin_len = 16'h0000;
  logic cout_v, cout_rdy, cout_soc, cin_v, cin_rdy, cin_soc, fout_v, fend, fend_e, lb_v;
  logic ais_fr, drop, end_e, fout_sof;
  logic [31:0] lb_h;
  logic [7:0] cout_d, cin_d, fout_d, lb_d;
  logic [15:0] fend_a, fend_l, end_a, end_l;
  logic [7:0] f[$], q[$], fout_q[$], lb_q[$];
  logic [7:0] c[52];
  int num_errors = 0, checks_done = 0, n_end = 0, n_ais = 0, n_drop = 0, n_sof = 0;
  int lens[6] = '{2, 40, 41, 88, 7, 0};
  logic [7:0] codes[2] = '{8'h18, 8'h10};
  always #50 clk = ~clk;
  always @(posedge clk) fout_rdy <= #1 ($urandom % 4) != 0;
  niw_converter #(.FIFO_DEPTH(4), .FIFO_AW(2)) niw_converter_i (
    .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_CFG_DLCI(dlci), .I_CFG_VPI(vpi), .I_CFG_VCI(vci),
    .I_CONGEST(cong), .I_FR_AIS(fr_ais), .I_FIN_VALID(fin_v), .O_FIN_READY(fin_rdy),
    .I_FIN_DATA(fin_d), .I_FIN_SOF(fin_sof), .I_FIN_EOF(fin_eof), .I_FIN_LEN(fin_len),
    .O_COUT_VALID(cout_v), .I_COUT_READY(cout_rdy), .O_COUT_DATA(cout_d), .O_COUT_SOC(cout_soc),
    .I_CIN_VALID(cin_v), .O_CIN_READY(cin_rdy), .I_CIN_DATA(cin_d), .I_CIN_SOC(cin_soc),
    .O_TRUNK_VLD(), .O_TRUNK_HDR(), .I_FOUT_READY(fout_rdy), .O_FOUT_VALID(fout_v),
    .O_FOUT_DATA(fout_d), .O_FOUT_SOF(fout_sof), .O_FEND(fend), .O_FEND_ADDR(fend_a),
    .O_FEND_LEN(fend_l), .O_FEND_ERR(fend_e), .O_LB_VALID(lb_v), .O_LB_SOC(), .O_LB_HDR(lb_h),
    .O_LB_DATA(lb_d), .O_AIS_TO_FR(ais_fr), .O_CELL_DROP(drop));
  niw_atm_model niw_atm_model_i (
    .clk(clk), .rst_n(rst_n), .cout_valid(cout_v), .cout_ready(cout_rdy),
    .cout_data(cout_d), .cout_soc(cout_soc), .cin_valid(cin_v), .cin_ready(cin_rdy),
    .cin_data(cin_d), .cin_soc(cin_soc));
  always @(posedge clk) begin
    if (fout_v && fout_sof) n_sof = fout_q.size();
    if (fout_v) fout_q.push_back(fout_d);
    if (lb_v) lb_q.push_back(lb_d);
    if (ais_fr) n_ais++;
    if (drop) n_drop++;
    if (fend) begin
      end_a = fend_a;
      end_l = fend_l;
      end_e = fend_e;
      n_end++;
    end
  end
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(inout int n);
    n++;
    @(posedge clk);
    if (n > 4000) begin
      num_errors++;
      finish_test();
    end
  endtask
  function automatic logic [31:0] hdr(input logic [2:0] pti, input logic clp);
    return {4'h0, vpi, vci, pti, clp};
  endfunction
  task automatic mk_frame(input int len, input logic de, input logic [9:0] dl);
    f.delete();
    f.push_back({dl[9:4], 2'h0});
    f.push_back({dl[3:0], 2'h0, de, 1'h1});
    for (int k = 2; k < len; k++) f.push_back(8'($urandom));
  endtask
  task automatic mk_cell(input logic [2:0] pti, input logic clp);
    logic [31:0] h;
    h = hdr(pti, clp);
    for (int j = 0; j < 52; j++) c[j] = j < 4 ? h[31 - 8 * j -: 8] : 8'($urandom);
  endtask
  task automatic send_frame();
    int n;
    @(posedge clk);
    #1;
    for (int i = 0; i < f.size(); i++) begin
      fin_v = 1'h1;
      fin_d = f[i];
      fin_sof = i == 0;
      fin_eof = i == f.size() - 1;
      fin_len = 16'(f.size());
      n = 0;
      @(posedge clk);
      while (!fin_rdy) step(n);
      #1;
    end
    fin_v = 1'h0;
    fin_sof = 1'h0;
    fin_eof = 1'h0;
  endtask
  task automatic grab(input int cnt);
    int n;
    n = 0;
    while (niw_atm_model_i.cap.size() < cnt) step(n);
    q = niw_atm_model_i.cap;
    niw_atm_model_i.cap.delete();
  endtask
  // ************************************************************
  // frame to cells, then the same cells back to a frame
  // ************************************************************
  task automatic run_frame(input int len, input logic de, input logic clpin,
                           input logic fe, input logic bad);
    int n, nc, b, e;
    nc = (len + 55) / 48;
    b = (nc - 1) * 52 + 44;
    mk_frame(len, de, dlci);
    send_frame();
    grab(nc * 52);
    for (int i = 0; i < nc; i++)
      `CHK({q[i*52], q[i*52+1], q[i*52+2], q[i*52+3]}, hdr({2'h0, i == nc - 1}, de))
    for (int p = 0; p < nc * 48 - 8; p++)
      `CHK(q[p / 48 * 52 + 4 + p % 48], p < len ? f[p] : 8'h00)
    `CHK({q[b], q[b+1], q[b+2], q[b+3]}, {16'h0000, len[15:0]})
    fout_q.delete();
    n_sof = -1;
    e = n_end;
    for (int i = 0; i < nc; i++) begin
      for (int j = 0; j < 52; j++) c[j] = q[i*52+j];
      c[3][0] = c[3][0] | (clpin && i == 0);
      c[3][2] = fe && i == nc - 1;
      if (bad && i == 0) c[9] = ~c[9];
      niw_atm_model_i.send_cell(c);
    end
    n = 0;
    while (n_end == e) step(n);
    `CHK(end_a, {f[0], f[1] | {4'h0, fe, 1'h0, clpin, 1'h0}})
    `CHK(end_l, len[15:0])
    `CHK(end_e, bad)
    `CHK(n_sof, 0)
    if (!bad)
      for (int k = 0; k < len - 2; k++)
        `CHK(fout_q[k], f[k+2])
  endtask
  initial begin
    int m, e, n;
    m = $urandom(32'h0000_3c02);
    dlci = 10'($urandom);
    vpi = 8'($urandom);
    vci = 16'($urandom);
    lens[5] = 2 + $urandom % 250;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    for (int i = 0; i < 6; i++) run_frame(lens[i], i[0], i == 2 || i == 4, i > 2, i == 5);
    // a frame for another connection must not reach the trunk
    mk_frame(30, 1'h0, dlci ^ 10'h001);
    send_frame();
    repeat (100) @(posedge clk);
    `CHK(niw_atm_model_i.cap.size(), 0)
    #1 fr_ais = 1'h1;
    @(posedge clk);
    #1 fr_ais = 1'h0;
    grab(52);
    for (int j = 0; j < 52; j++)
      `CHK(q[j], j < 4 ? hdr(3'h5, 1'h0) >> (24 - 8 * j) & 32'h0000_00ff : j == 4 ? 8'h10 : 8'h6a)
    foreach (codes[i]) begin
      lb_q.delete();
      fout_q.delete();
      m = n_ais;
      mk_cell(3'h5, 1'h0);
      c[4] = codes[i];
      niw_atm_model_i.send_cell(c);
      repeat (4) @(posedge clk);
      if (i == 0)
        for (int j = 0; j < 48; j++)
          `CHK(lb_q[j], j == 1 ? c[5] & 8'hfe : c[4+j])
      else
        `CHK(n_ais, m + 1)
      `CHK(fout_q.size(), 0)
    end
    `CHK(lb_h, hdr(3'h5, 1'h0))
    #1 cong = 1'h1;
    m = n_drop;
    e = n_end;
    mk_cell(3'h0, 1'h1);
    niw_atm_model_i.send_cell(c);
    mk_cell(3'h1, 1'h0);
    niw_atm_model_i.send_cell(c);
    n = 0;
    while (n_end == e) step(n);
    `CHK(n_drop, m + 1)
    `CHK(end_e, 1'h1)
    `CHK(niw_atm_model_i.stuck, 0)
    finish_test();
  end
endmodule
`default_nettype wire
